/* File: uie_irq_enable.sv */
// interrupt source enable mask with APB register access and irq output
//
// Local design decision: register access over APB.
`include "uie_consts.svh"

module uie_irq_enable
  import uie_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int NUM_DATA_EP = 7
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // apb slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // handshake reports from the serial engine
  input wire logic hs_evt,
  input wire logic hs_ack,
  input wire logic [2:0] hs_ep,
  input wire logic hs_in,
  input wire logic hs_setup,
  // bus event pulses
  input wire logic bus_reset_evt,
  input wire logic frame_start_evt,
  input wire logic pseudo_frame_evt,
  input wire logic suspend_evt,
  input wire logic resume_evt,
  input wire logic speed_status_evt,
  input wire logic dma_reason_evt,
  input wire logic supply_sense_evt,
  // interrupt result
  output logic irq,
  output logic [31:0] irq_active
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  uie_state_t st_r;
  uie_state_t st_nxt;

  logic [31:0] hs_set;
  logic [31:0] bus_set;
  logic [31:0] rd_val;
  logic rd_hit;
  logic wr_acc;
  logic setup_ph;

  // --------------------------------------------------------------------------
  // handshake filter
  // --------------------------------------------------------------------------
  uie_hs_filter #(
    .NUM_DATA_EP(NUM_DATA_EP)
  ) u_filter (
    .hs_evt(hs_evt),
    .hs_ack(hs_ack),
    .hs_ep(hs_ep),
    .hs_in(hs_in),
    .hs_setup(hs_setup),
    .cmode(st_r.cmode),
    .imode(st_r.imode),
    .omode(st_r.omode),
    .set_vec(hs_set)
  );

  // --------------------------------------------------------------------------
  // bus event mapping
  // --------------------------------------------------------------------------
  always_comb begin
    bus_set = '0;
    bus_set[`UIE_B_BUS_RESET] = bus_reset_evt; // RULE_16
    bus_set[`UIE_B_FRAME] = frame_start_evt; // RULE_15
    bus_set[`UIE_B_PSEUDO_FRAME] = pseudo_frame_evt; // RULE_15
    bus_set[`UIE_B_SUSPEND] = suspend_evt; // RULE_14
    bus_set[`UIE_B_RESUME] = resume_evt; // RULE_13
    bus_set[`UIE_B_SPEED] = speed_status_evt; // RULE_12
    bus_set[`UIE_B_DMA] = dma_reason_evt; // RULE_11
    bus_set[`UIE_B_SUPPLY] = supply_sense_evt; // RULE_10
  end

  // --------------------------------------------------------------------------
  // register read mux
  // --------------------------------------------------------------------------
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (paddr)
      ADDR_W'(`UIE_OFS_MODE): begin
        rd_val[`UIE_B_GLOBAL] = st_r.glob;
      end
      ADDR_W'(`UIE_OFS_ICFG): begin
        rd_val[`UIE_F_CMODE_LSB +: 2] = st_r.cmode;
        rd_val[`UIE_F_IMODE_LSB +: 2] = st_r.imode;
        rd_val[`UIE_F_OMODE_LSB +: 2] = st_r.omode;
      end
      ADDR_W'(`UIE_OFS_IEN): begin
        rd_val = st_r.en & `UIE_EN_MASK; // RULE_01 RULE_04
      end
      ADDR_W'(`UIE_OFS_PEND): begin
        rd_val = st_r.pend;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;

  always_comb begin
    st_nxt = st_r;
    // software writes land in the access phase
    if (wr_acc) begin
      case (paddr)
        ADDR_W'(`UIE_OFS_MODE): begin
          st_nxt.glob = pwdata[`UIE_B_GLOBAL];
        end
        ADDR_W'(`UIE_OFS_ICFG): begin
          st_nxt.cmode = uie_hs_mode_t'(pwdata[`UIE_F_CMODE_LSB +: 2]); // RULE_08
          st_nxt.imode = uie_hs_mode_t'(pwdata[`UIE_F_IMODE_LSB +: 2]); // RULE_07
          st_nxt.omode = uie_hs_mode_t'(pwdata[`UIE_F_OMODE_LSB +: 2]); // RULE_07
        end
        ADDR_W'(`UIE_OFS_IEN): begin
          // reserved bits are dropped so they always read zero
          st_nxt.en = pwdata & `UIE_EN_MASK; // RULE_01 RULE_04
        end
        ADDR_W'(`UIE_OFS_PEND): begin
          st_nxt.pend = st_r.pend & ~pwdata;
        end
        default: begin
          st_nxt.en = st_r.en;
        end
      endcase
    end
    // bus reset beats a software write in the same cycle
    if (bus_reset_evt) begin
      st_nxt.en = `UIE_EN_BUSRST; // RULE_09
    end
    // a new event wins over a write-one-to-clear in the same cycle
    st_nxt.pend = st_nxt.pend | ((hs_set | bus_set) & `UIE_EN_MASK); // RULE_06
    st_nxt.active = st_nxt.pend & st_nxt.en; // RULE_17
    st_nxt.irq = st_nxt.glob && (|st_nxt.active); // RULE_05 RULE_17
    // read data is caught in the setup phase so the access needs no wait state
    if (setup_ph) begin
      st_nxt.prdata = pwrite ? 32'h0000_0000 : rd_val;
      st_nxt.pslverr = !rd_hit;
    end
    if (!rstn) begin
      st_nxt.en = `UIE_EN_RST; // RULE_17
      st_nxt.pend = `UIE_PEND_RST;
      st_nxt.glob = `UIE_GLOBAL_RST;
      st_nxt.cmode = UIE_HS_BOTH;
      st_nxt.imode = UIE_HS_BOTH;
      st_nxt.omode = UIE_HS_BOTH;
      st_nxt.irq = 1'b0;
      st_nxt.active = '0;
      st_nxt.prdata = '0;
      st_nxt.pslverr = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    st_r <= st_nxt;
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign prdata = st_r.prdata;
  assign pslverr = st_r.pslverr && psel && penable;
  assign pready = 1'b1;
  assign irq = st_r.irq;
  assign irq_active = st_r.active;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking

  default disable iff (!rstn);

  property p_ien_write;
    wr_acc && (paddr == ADDR_W'(`UIE_OFS_IEN)) && !bus_reset_evt
      |=> st_r.en == ($past(pwdata) & `UIE_EN_MASK);
  endproperty
  a_ien_write: assert property (p_ien_write) // RULE_01
    else $error("enable register did not take the written value");

  property p_reserved_read;
    setup_ph && !pwrite && (paddr == ADDR_W'(`UIE_OFS_IEN))
      |=> ((prdata & ~`UIE_EN_MASK) == 32'h0000_0000) && !st_r.pslverr;
  endproperty
  a_reserved_read: assert property (p_reserved_read) // RULE_04
    else $error("reserved enable bits read non-zero");

  property p_global_off;
    !st_r.glob |-> !irq;
  endproperty
  a_global_off: assert property (p_global_off) // RULE_05
    else $error("irq raised with global enable clear");

  property p_irq_cause;
    irq == (st_r.glob && (|(st_r.pend & st_r.en)));
  endproperty
  a_irq_cause: assert property (p_irq_cause) // RULE_17
    else $error("irq does not match pending, enable and global state");

  property p_bus_reset_en;
    bus_reset_evt |=> (st_r.en == `UIE_EN_BUSRST) && st_r.pend[`UIE_B_BUS_RESET];
  endproperty
  a_bus_reset_en: assert property (p_bus_reset_en) // RULE_09
    else $error("bus reset did not force the enable mask");

  property p_bus_reset_irq;
    bus_reset_evt && st_r.glob && !(wr_acc && (paddr == ADDR_W'(`UIE_OFS_MODE)))
      |=> irq;
  endproperty
  a_bus_reset_irq: assert property (p_bus_reset_irq) // RULE_16
    else $error("bus reset with global enable set gave no irq");

  property p_ep3_in;
    hs_evt && hs_in && (hs_ep == 3'h3) && (st_r.imode == UIE_HS_BOTH)
      |=> st_r.pend[`UIE_B_EP_BASE + 5];
  endproperty
  a_ep3_in: assert property (p_ep3_in) // RULE_07
    else $error("data IN handshake did not set its transmit pending bit");

  property p_ep1_out_filter;
    hs_evt && !hs_ack && !hs_in && (hs_ep == 3'h1) && (st_r.omode == UIE_HS_ACK)
      && !st_r.pend[`UIE_B_EP_BASE] |=> !st_r.pend[`UIE_B_EP_BASE];
  endproperty
  a_ep1_out_filter: assert property (p_ep1_out_filter) // RULE_06
    else $error("NAK passed an ACK-only filter");

  property p_setup;
    hs_evt && hs_setup && (hs_ep == 3'h0) && (st_r.cmode != UIE_HS_OFF)
      && ((st_r.cmode == UIE_HS_BOTH) || (hs_ack == (st_r.cmode == UIE_HS_ACK)))
      |=> st_r.pend[`UIE_B_SETUP];
  endproperty
  a_setup: assert property (p_setup) // RULE_08
    else $error("endpoint 0 setup did not set its pending bit");

  property p_set_wins;
    suspend_evt && wr_acc && (paddr == ADDR_W'(`UIE_OFS_PEND)) |=> st_r.pend[`UIE_B_SUSPEND];
  endproperty
  a_set_wins: assert property (p_set_wins) // RULE_14
    else $error("suspend event lost to a pending clear");

  // --------------------------------------------------------------------------
  // event capture, register and reset assertions
  // --------------------------------------------------------------------------

  // checked while reset is low too, so it overrides the default disable
  property p_reset_clear;
    disable iff (1'b0)
    !rstn |=> (st_r.en == `UIE_EN_RST) && (st_r.pend == `UIE_PEND_RST) && !st_r.glob && !irq;
  endproperty
  a_reset_clear: assert property (p_reset_clear) // RULE_17
    else $error("reset left enable, pending or irq state set");

  property p_frame_pend;
    frame_start_evt |=> st_r.pend[`UIE_B_FRAME];
  endproperty
  a_frame_pend: assert property (p_frame_pend) // RULE_15
    else $error("start-of-frame event did not set its pending bit");

  property p_pseudo_pend;
    pseudo_frame_evt |=> st_r.pend[`UIE_B_PSEUDO_FRAME];
  endproperty
  a_pseudo_pend: assert property (p_pseudo_pend) // RULE_15
    else $error("pseudo start-of-frame event did not set its pending bit");

  property p_suspend_pend;
    suspend_evt |=> st_r.pend[`UIE_B_SUSPEND];
  endproperty
  a_suspend_pend: assert property (p_suspend_pend) // RULE_14
    else $error("suspend event did not set its pending bit");

  property p_resume_pend;
    resume_evt |=> st_r.pend[`UIE_B_RESUME];
  endproperty
  a_resume_pend: assert property (p_resume_pend) // RULE_13
    else $error("resume event did not set its pending bit");

  property p_speed_pend;
    speed_status_evt |=> st_r.pend[`UIE_B_SPEED];
  endproperty
  a_speed_pend: assert property (p_speed_pend) // RULE_12
    else $error("speed status event did not set its pending bit");

  property p_dma_pend;
    dma_reason_evt |=> st_r.pend[`UIE_B_DMA];
  endproperty
  a_dma_pend: assert property (p_dma_pend) // RULE_11
    else $error("dma reason event did not set its pending bit");

  property p_supply_pend;
    supply_sense_evt |=> st_r.pend[`UIE_B_SUPPLY];
  endproperty
  a_supply_pend: assert property (p_supply_pend) // RULE_10
    else $error("supply sense event did not set its pending bit");

  property p_reserved_zero;
    ((st_r.en | st_r.pend) & ~`UIE_EN_MASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // RULE_04
    else $error("a reserved enable or pending bit is set");

  property p_mode_write;
    wr_acc && (paddr == ADDR_W'(`UIE_OFS_MODE))
      |=> st_r.glob == $past(pwdata[`UIE_B_GLOBAL]);
  endproperty
  a_mode_write: assert property (p_mode_write) // RULE_05
    else $error("global enable did not take the written value");

  property p_ctrl_in;
    hs_evt && hs_in && !hs_setup && (hs_ep == 3'h0) && (st_r.cmode == UIE_HS_BOTH)
      |=> st_r.pend[`UIE_B_CTRL_IN];
  endproperty
  a_ctrl_in: assert property (p_ctrl_in) // RULE_03
    else $error("control IN handshake did not set its pending bit");

  property p_ctrl_off;
    hs_evt && (hs_ep == 3'h0) && (st_r.cmode == UIE_HS_OFF)
      && (st_r.pend[`UIE_B_CTRL_IN:`UIE_B_SETUP] == 4'h0)
      |=> st_r.pend[`UIE_B_CTRL_IN:`UIE_B_SETUP] == 4'h0;
  endproperty
  a_ctrl_off: assert property (p_ctrl_off) // RULE_08
    else $error("endpoint 0 handshake passed a closed control filter");

  property p_ep5_out;
    hs_evt && !hs_in && (hs_ep == 3'h5) && (st_r.omode == UIE_HS_BOTH)
      |=> st_r.pend[`UIE_B_EP_BASE + 8];
  endproperty
  a_ep5_out: assert property (p_ep5_out) // RULE_02
    else $error("data OUT handshake did not set its receive pending bit");

  // scenario coverage
  c_irq_rise: cover property ($rose(irq));
  c_bus_reset: cover property (bus_reset_evt ##1 irq);
  c_slverr: cover property (psel && penable && pslverr);
  c_ep_irq: cover property (hs_evt && hs_ep != 3'h0 ##1 irq);

endmodule : uie_irq_enable

/* File: uie_consts.svh */
// constants of the interrupt source enable block
`ifndef UIE_CONSTS_SVH
`define UIE_CONSTS_SVH
// What this block does
// [RULE_01] the enable mask is one 32-bit register at byte offset 0x14
// [RULE_02] bits 12..25 enable data endpoints 1..7, receive even bit, transmit odd bit
// [RULE_03] bit 11 enables control IN endpoint 0, bit 10 control OUT endpoint 0
// [RULE_04] bit 8 enables setup-received; bit 9 and bits 26..31 are reserved
// [RULE_05] clearing the global enable suppresses every interrupt
// [RULE_06] endpoint events come from ACK or NAK handshakes, filtered by mode fields
// [RULE_07] data IN follows the IN mode field, data OUT follows the OUT mode field
// [RULE_08] endpoint 0 IN, OUT and setup events follow the control mode field
// [RULE_09] a bus reset clears all enables except bus-reset enable, which becomes 1
// [RULE_10] bit 7 enables the supply sensing interrupt
// [RULE_11] bit 6 enables the interrupt on a DMA reason register change
// [RULE_12] bit 5 enables the interrupt on a high-speed status change
// [RULE_13] bit 4 enables the interrupt on a resume state
// [RULE_14] bit 3 enables the interrupt on a suspend state
// [RULE_15] bit 2 enables pseudo start-of-frame, bit 1 real start-of-frame interrupts
// [RULE_16] bit 0 enables the bus reset interrupt
// [RULE_17] irq needs a pending event, its enable and global enable; enables reset to 0

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define UIE_OFS_MODE 12'h00C
`define UIE_OFS_ICFG 12'h010
`define UIE_OFS_IEN 12'h014
`define UIE_OFS_PEND 12'h018

// ----------------------------------------------------------------------------
// enable and pending bit positions
// ----------------------------------------------------------------------------
`define UIE_B_BUS_RESET 0
`define UIE_B_FRAME 1
`define UIE_B_PSEUDO_FRAME 2
`define UIE_B_SUSPEND 3
`define UIE_B_RESUME 4
`define UIE_B_SPEED 5
`define UIE_B_DMA 6
`define UIE_B_SUPPLY 7
`define UIE_B_SETUP 8
`define UIE_B_CTRL_OUT 10
`define UIE_B_CTRL_IN 11
`define UIE_B_EP_BASE 12

// ----------------------------------------------------------------------------
// mode and configuration field positions
// ----------------------------------------------------------------------------
`define UIE_B_GLOBAL 0
`define UIE_F_CMODE_LSB 0
`define UIE_F_IMODE_LSB 2
`define UIE_F_OMODE_LSB 4

// ----------------------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------------------
`define UIE_EN_MASK 32'h03FF_FDFF
`define UIE_EN_RST 32'h0000_0000
`define UIE_EN_BUSRST 32'h0000_0001
`define UIE_PEND_RST 32'h0000_0000
`define UIE_GLOBAL_RST 1'b0

`endif

/* File: uie_pkg.sv */
// types of the interrupt source enable block
package uie_pkg;

  // handshake filter modes held in the configuration register
  typedef enum logic [1:0] {
    UIE_HS_BOTH,
    UIE_HS_ACK,
    UIE_HS_NAK,
    UIE_HS_OFF
  } uie_hs_mode_t;

  // whole state of the enable block
  typedef struct packed {
    logic [31:0] en;
    logic [31:0] pend;
    logic glob;
    uie_hs_mode_t cmode;
    uie_hs_mode_t imode;
    uie_hs_mode_t omode;
    logic irq;
    logic [31:0] active;
    logic [31:0] prdata;
    logic pslverr;
  } uie_state_t;

endpackage : uie_pkg

/* File: uie_hs_filter.sv */
// handshake event filter: maps ACK/NAK handshakes to pending set bits
`include "uie_consts.svh"

module uie_hs_filter
  import uie_pkg::*;
#(
  parameter int NUM_DATA_EP = 7
) (
  // handshake report from the serial engine
  input wire logic hs_evt,
  input wire logic hs_ack,
  input wire logic [2:0] hs_ep,
  input wire logic hs_in,
  input wire logic hs_setup,
  // filter modes
  input wire uie_hs_mode_t cmode,
  input wire uie_hs_mode_t imode,
  input wire uie_hs_mode_t omode,
  // pending bits to set
  output logic [31:0] set_vec
);

  function automatic logic hs_pass(input uie_hs_mode_t m, input logic ack);
    logic r;
    r = 1'b0;
    case (m)
      UIE_HS_BOTH: r = 1'b1;
      UIE_HS_ACK: r = ack;
      UIE_HS_NAK: r = !ack;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : hs_pass

  logic ctrl_take;

  assign ctrl_take = hs_evt && (hs_ep == 3'h0) && hs_pass(cmode, hs_ack); // RULE_06 RULE_08

  assign set_vec[`UIE_B_SUPPLY:0] = '0;
  assign set_vec[9] = 1'b0;
  assign set_vec[31:`UIE_B_EP_BASE + 2 * NUM_DATA_EP] = '0;
  assign set_vec[`UIE_B_SETUP] = ctrl_take && hs_setup; // RULE_08 RULE_04
  assign set_vec[`UIE_B_CTRL_OUT] = ctrl_take && !hs_setup && !hs_in; // RULE_08 RULE_03
  assign set_vec[`UIE_B_CTRL_IN] = ctrl_take && !hs_setup && hs_in; // RULE_08 RULE_03

  for (genvar n = 1; n <= NUM_DATA_EP; n++) begin : g_ep
    logic hit;
    assign hit = hs_evt && (hs_ep == 3'(n));
    // receive on the even bit, transmit on the odd bit
    assign set_vec[`UIE_B_EP_BASE + 2 * (n - 1)] = hit && !hs_in && hs_pass(omode, hs_ack); // RULE_02 RULE_07
    assign set_vec[`UIE_B_EP_BASE + 2 * (n - 1) + 1] = hit && hs_in && hs_pass(imode, hs_ack); // RULE_02 RULE_07
  end

endmodule : uie_hs_filter

/* File: uie_sie_model.sv */
// serial engine stand-in: issues handshake reports and bus event pulses
module uie_sie_model (
  // clock
  input wire logic mclk,
  // handshake report
  output logic hs_evt,
  output logic hs_ack,
  output logic [2:0] hs_ep,
  output logic hs_in,
  output logic hs_setup,
  // bus event pulses, index is the enable bit position
  output logic [7:0] bus_evt
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hs_evt = 1'b0;
    hs_ack = 1'b0;
    hs_ep = 3'h0;
    hs_in = 1'b0;
    hs_setup = 1'b0;
    bus_evt = 8'h00;
  end

  // ---------------------------------------------------------------------------
  // one-cycle reports
  // ---------------------------------------------------------------------------
  // qualifiers are inverted once the pulse is gone so stale values never match
  task send_hs(input logic [2:0] ep, input logic dir_in, input logic ack, input logic setup);
    @(posedge mclk);
    hs_evt <= 1'b1;
    hs_ep <= ep;
    hs_in <= dir_in;
    hs_ack <= ack;
    hs_setup <= setup;
    @(posedge mclk);
    hs_evt <= 1'b0;
    hs_ep <= ~ep;
    hs_in <= ~dir_in;
    hs_ack <= ~ack;
    hs_setup <= ~setup;
  endtask : send_hs

  task pulse(input int b);
    @(posedge mclk);
    bus_evt[b] <= 1'b1;
    @(posedge mclk);
    bus_evt[b] <= 1'b0;
  endtask : pulse
endmodule : uie_sie_model

/* File: usb_device_interrupt_enable_bench.sv */
// self-checking bench of the interrupt source enable block
`include "uie_consts.svh"

module usb_device_interrupt_enable_bench
  import uie_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hs_evt, hs_ack, hs_in, hs_setup, irq;
  logic [2:0] hs_ep;
  logic [7:0] bus_evt;
  logic [31:0] irq_active;
  logic [31:0] q;
  logic e;
  int fail_count = 0;
  int comparisons = 0;

  always #5 mclk = ~mclk;

  uie_sie_model sie_u (.mclk(mclk), .hs_evt(hs_evt), .hs_ack(hs_ack), .hs_ep(hs_ep),
    .hs_in(hs_in), .hs_setup(hs_setup), .bus_evt(bus_evt));

  uie_irq_enable #(.ADDR_W(12), .NUM_DATA_EP(7)) dut_u (.mclk(mclk), .rstn(rstn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hs_evt(hs_evt), .hs_ack(hs_ack),
    .hs_ep(hs_ep), .hs_in(hs_in), .hs_setup(hs_setup), .bus_reset_evt(bus_evt[0]),
    .frame_start_evt(bus_evt[1]), .pseudo_frame_evt(bus_evt[2]), .suspend_evt(bus_evt[3]),
    .resume_evt(bus_evt[4]), .speed_status_evt(bus_evt[5]), .dma_reason_evt(bus_evt[6]),
    .supply_sense_evt(bus_evt[7]), .irq(irq), .irq_active(irq_active));

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task summarize;
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // the leading edge puts every request just after a rising edge, one assignment per step
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!(pready === 1'b1) && n < 50);
    if (n >= 50) fail_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task settle;
    @(posedge mclk);
    #1;
  endtask : settle

  function automatic logic takes(input int m, input logic ack);
    return m == 0 || (m == 1 && ack) || (m == 2 && !ack);
  endfunction : takes

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task t_reset;
    apb(`UIE_OFS_IEN, 1'b0, 32'h0);
    check("enable after reset", q, 32'h0000_0000);
    apb(`UIE_OFS_PEND, 1'b0, 32'h0);
    check("pending after reset", q, 32'h0000_0000);
    check("irq after reset", 32'(irq), 32'h0);
  endtask : t_reset

  task t_mask;
    wr(12'h014, 32'hFFFF_FFFF);
    apb(12'h014, 1'b0, 32'h0);
    check("enable mask", q, 32'h03FF_FDFF);
    wr(12'h3F0, 32'hFFFF_FFFF);
    apb(12'h3F0, 1'b0, 32'h0);
    check("unmapped data", q, 32'h0);
    check("unmapped error", 32'(e), 32'h1);
    wr(12'h014, 32'h0000_0000);
    apb(12'h014, 1'b0, 32'h0);
    check("enable cleared", q, 32'h0000_0000);
  endtask : t_mask

  task t_bus_events;
    wr(`UIE_OFS_MODE, 32'h0000_0001);
    for (int b = 0; b < 8; b++) begin
      wr(`UIE_OFS_IEN, 32'h1 << b);
      sie_u.pulse(b);
      settle();
      check("bus event active", irq_active, 32'h1 << b);
      check("bus event irq", 32'(irq), 32'h1);
      wr(`UIE_OFS_PEND, 32'h1 << b);
    end
    wr(`UIE_OFS_MODE, 32'h0000_0000);
    wr(`UIE_OFS_IEN, 32'h0000_0008);
    sie_u.pulse(3);
    settle();
    check("global off active", irq_active, 32'h0000_0008);
    check("global off irq", 32'(irq), 32'h0);
    // the suspend pulse is lined up with the access edge of the clearing write
    fork
      wr(`UIE_OFS_PEND, 32'h0000_0008);
      begin
        @(posedge mclk);
        sie_u.pulse(3);
      end
    join
    apb(`UIE_OFS_PEND, 1'b0, 32'h0);
    check("set beats clear", q, 32'h0000_0008);
    wr(`UIE_OFS_PEND, 32'hFFFF_FFFF);
  endtask : t_bus_events

  // one field open at a time, the other two set to report nothing
  task t_handshake;
    logic [31:0] exp;
    wr(`UIE_OFS_MODE, 32'h0000_0001);
    wr(`UIE_OFS_IEN, 32'h0000_0000);
    for (int f = 0; f < 3; f++) begin
      for (int m = 0; m < 4; m++) begin
        for (int a = 0; a < 2; a++) begin
          wr(`UIE_OFS_ICFG, (32'h3F & ~(32'h3 << 2 * f)) | (m << 2 * f));
          sie_u.send_hs(3'd0, 1'b0, a[0], 1'b1);
          sie_u.send_hs(3'd0, 1'b1, a[0], 1'b0);
          sie_u.send_hs(3'd0, 1'b0, a[0], 1'b0);
          sie_u.send_hs(3'd3, 1'b1, a[0], 1'b0);
          sie_u.send_hs(3'd3, 1'b0, a[0], 1'b0);
          apb(`UIE_OFS_PEND, 1'b0, 32'h0);
          exp = (f == 0) ? 32'h0000_0D00 : (f == 1) ? 32'h0002_0000 : 32'h0001_0000;
          check("filtered pending", q, takes(m, a[0]) ? exp : 32'h0);
          check("disabled irq", 32'(irq), 32'h0);
          wr(`UIE_OFS_PEND, 32'hFFFF_FFFF);
        end
      end
    end
  endtask : t_handshake

  task t_pairing;
    wr(`UIE_OFS_ICFG, 32'h0000_0000);
    wr(`UIE_OFS_IEN, 32'hFFFF_FFFF);
    for (int n = 1; n < 8; n++) begin
      sie_u.send_hs(n[2:0], 1'b0, 1'b1, 1'b0);
      sie_u.send_hs(n[2:0], 1'b1, 1'b0, 1'b0);
      settle();
      check("endpoint active", irq_active, 32'h3 << (12 + 2 * (n - 1)));
      check("endpoint irq", 32'(irq), 32'h1);
      wr(`UIE_OFS_PEND, 32'hFFFF_FFFF);
    end
  endtask : t_pairing

  task t_bus_reset;
    wr(`UIE_OFS_IEN, 32'hFFFF_FFFF);
    sie_u.pulse(0);
    settle();
    apb(`UIE_OFS_IEN, 1'b0, 32'h0);
    check("enable after bus reset", q, 32'h0000_0001);
    apb(`UIE_OFS_PEND, 1'b0, 32'h0);
    check("pending after bus reset", q, 32'h0000_0001);
    check("bus reset irq", 32'(irq), 32'h1);
  endtask : t_bus_reset

  // ---------------------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_mask();
    t_bus_events();
    t_handshake();
    t_pairing();
    t_bus_reset();
    summarize();
  end

  // the full run needs roughly 660 cycles
  initial begin
    #300000;
    fail_count++;
    summarize();
  end
endmodule : usb_device_interrupt_enable_bench
